// file: bench/tb_wake_reset_direct_input_ctrl.sv
// self-checking bench of the wake, reset and direct-input control
`timescale 1ns/1ps
module tb_wake_reset_direct_input_ctrl;
  import wrd_pkg::*;
  logic        clk, rst_n, reset_pin, wake_pin, failsafe_select_in, vdd_fail;
  logic        so, so_oe, pwm_clk, fault_flag_n_out, fault_flag_n_oe;
  logic        awake, failsafe, wdog_running;
  logic [3:0]  direct_in, fault_in, high_side_outputs;
  logic [15:0] rx;
  wrd_spi_t    spi;
  wrd_sense_t  current_sense_out;
  int          bad_count, n_compared;
  // short watchdog so a run stays brief
  wrd_ctrl #(.WDOG_CYCLES(3000)) uut (.clk, .rst_n, .reset_pin, .wake_pin,
    .direct_in, .failsafe_select_in, .vdd_fail, .fault_in, .spi, .so, .so_oe,
    .high_side_outputs, .pwm_clk, .current_sense_out, .fault_flag_n_out,
    .fault_flag_n_oe, .awake, .failsafe, .wdog_running);
  wrd_host host (.clk, .so, .spi);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // wake sources, direct drive, watchdog start
  task automatic t_wake;
    step(3);
    check(awake, 1'b0);
    wake_pin = 1'b1;
    step(2);
    check(awake, 1'b1);
    wake_pin = 1'b0;
    // pwm clock fed on input zero
    direct_in = 4'h1;
    step(2);
    check(awake, 1'b1);
    check(high_side_outputs, 4'h1);
    check(pwm_clk, 1'b1);
    direct_in = 4'h0;
    reset_pin = 1'b1;
    step(2);
    check(awake, 1'b1);
    check(wdog_running, 1'b1);
    // 5 us before the first frame
    step(250);
  endtask
  // register writes, then fault flag and status read
  task automatic t_spi;
    host.frame(16'h200a, rx);
    check(high_side_outputs, 4'ha);
    host.frame(16'h100c, rx);
    check(current_sense_out, {1'b1, WRD_SEL_TEMP});
    host.frame(16'h1002, rx);
    check(current_sense_out, {1'b0, WRD_SEL_HS2});
    fault_in = 4'h5;
    step(2);
    check(fault_flag_n_oe, 1'b1);
    fault_in = 4'h0;
    host.frame(16'h0000, rx);
    check(rx, 16'h05a0);
    host.frame(16'h3005, rx);
    check(fault_flag_n_oe, 1'b0);
  endtask
  // reset pin low clears state; then failsafe drive
  task automatic t_reset;
    fault_in = 4'h2;
    step(2);
    fault_in = 4'h0;
    reset_pin = 1'b0;
    step(RST_LOW_CYC);
    check(high_side_outputs, OUT_RST);
    check(current_sense_out, {1'b1, SENSE_RST});
    check(fault_flag_n_oe, 1'b0);
    check(awake, 1'b0);
    reset_pin = 1'b1;
    step(250);
    host.frame(16'h2006, rx);
    vdd_fail = 1'b1;
    direct_in = 4'h9;
    step(3);
    check(failsafe, 1'b1);
    check(high_side_outputs, 4'h9);
    check(so_oe, 1'b0);
    // supply back; software bits and direct inputs combine again
    vdd_fail = 1'b0;
    step(3);
    check(failsafe, 1'b0);
    check(high_side_outputs, 4'hf);
    // no frames for longer than the 3000-cycle watchdog
    step(3100);
    check(failsafe, 1'b1);
    check(high_side_outputs, 4'h9);
  endtask
  initial begin
    rst_n = 1'b0;
    reset_pin = 1'b0;
    wake_pin = 1'b0;
    direct_in = 4'h0;
    failsafe_select_in = 1'b1;
    vdd_fail = 1'b0;
    fault_in = 4'h0;
    bad_count = 0;
    n_compared = 0;
    step(12);
    rst_n = 1'b1;
    t_wake;
    t_spi;
    t_reset;
    final_report;
  end
  // hang guard, about twice the expected run
  initial begin
    repeat (12000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule

// file: bench/wrd_ctrl_properties.sv
// checker of wake, reset, direct-input and fault-flag ports
`timescale 1ns/1ps
module wrd_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reset_pin,
  input wire logic       wake_pin,
  input wire logic [3:0] direct_in,
  input wire logic       failsafe_select_in,
  input wire logic [3:0] fault_in,
  input wire logic [3:0] high_side_outputs,
  input wire logic       pwm_clk,
  input wire logic       fault_flag_n_out,
  input wire logic       fault_flag_n_oe,
  input wire logic       awake,
  input wire logic       failsafe,
  input wire logic       wdog_running,
  input wire logic       so_oe,
  input wire wrd_pkg::wrd_spi_t spi
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // two edges with every wake source off
  sequence s_quiet;
    (!reset_pin && !wake_pin && direct_in == 4'h0) [*2];
  endsequence
  // two edges of reset low with no fault present
  sequence s_clear;
    (!reset_pin && fault_in == 4'h0) [*2];
  endsequence
  a_pwm_relay: assert property (pwm_clk == $past(direct_in[0]))
    else $error("pwm clock not relayed");
  a_direct_drive: assert property (!failsafe && !$past(failsafe)
    && $stable(direct_in) && $past(direct_in, 2) == direct_in
    |-> (high_side_outputs & direct_in) == direct_in)
    else $error("direct input not driving output");
  a_so_enable: assert property ($past(reset_pin) |->
    so_oe == !$past(spi.cs_n)) else $error("serial output enable wrong");
  a_flag_assert: assert property (fault_in != 4'h0 |=>
    fault_flag_n_oe && !fault_flag_n_out) else $error("fault flag not low");
  a_flag_release: assert property (s_clear |=> !fault_flag_n_oe)
    else $error("fault flag not released");
  a_reset_sleep: assert property (s_quiet |-> !awake)
    else $error("awake with no wake source");
  a_reset_wake: assert property (reset_pin [*2] |-> awake)
    else $error("reset high did not wake");
  a_wake_pin: assert property (wake_pin [*2] |-> awake)
    else $error("wake pin did not wake");
  a_direct_wake: assert property ((|direct_in) [*2] |-> awake)
    else $error("direct input did not wake");
  a_wdog_start: assert property ($rose(reset_pin) && failsafe_select_in
    |-> ##[1:2] wdog_running) else $error("watchdog not started");
endmodule
bind wrd_ctrl wrd_props u_props (.clk, .rst_n, .reset_pin, .wake_pin,
  .direct_in, .failsafe_select_in, .fault_in, .high_side_outputs, .pwm_clk,
  .fault_flag_n_out, .fault_flag_n_oe, .awake, .failsafe, .wdog_running,
  .so_oe, .spi);

// file: bench/wrd_host.sv
// host model that drives whole serial frames
`timescale 1ns/1ps
module wrd_host (
  input  wire logic         clk,
  input  wire logic         so,
  output wrd_pkg::wrd_spi_t spi
);
  import wrd_pkg::*;
  // idle: select high, clock and data at pull-down level
  initial spi = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
  // sixteen bits msb first, reply read after each rise
  task automatic frame(input logic [15:0] w, output logic [15:0] rx);
    @(negedge clk);
    spi.cs_n = 1'b0;
    repeat (25) @(negedge clk);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      spi.si = w[i];
      // four cycles a level, 6.25 MHz
      spi.sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx[i] = so;
      spi.sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    spi.cs_n = 1'b1;
    spi.si = 1'b0;
    // select high 1 us between frames
    repeat (50) @(negedge clk);
  endtask
endmodule

// file: verilog/wrd_ctrl.sv
// wake, reset, direct-input and fault-flag control of a quad lamp switch
`timescale 1ns/1ps
// How it works
// - software picks sense quantity, current or temperature
// - software can tri-state the sense output
// - any direct input wakes the device
// - direct input n switches output n
// - external pwm clock taken from input zero
// - fault flag pulled low on any fault
// - fault detail only via serial data
// - wake pin wakes the device
// - reset high also wakes the device
// - reset low clears config and fault registers
// - reset low forces sleep mode unless the wake pin or a direct input is high
// - reset rising edge starts the watchdog
// - frame is sixteen bits, msb first
// - select rising edge loads addressed register
// - failsafe drives outputs from direct inputs
module wrd_ctrl #(
  parameter int WDOG_CYCLES = wrd_pkg::WDOG_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              reset_pin,
  input  wire logic              wake_pin,
  input  wire logic [3:0]        direct_in,
  input  wire logic              failsafe_select_in,
  input  wire logic              vdd_fail,
  input  wire logic [3:0]        fault_in,
  input  wire wrd_pkg::wrd_spi_t spi,
  output logic                   so,
  output logic                   so_oe,
  output logic [3:0]             high_side_outputs,
  output logic                   pwm_clk,
  output wrd_pkg::wrd_sense_t    current_sense_out,
  output logic                   fault_flag_n_out,
  output logic                   fault_flag_n_oe,
  output logic                   awake,
  output logic                   failsafe,
  output logic                   wdog_running
);
  import wrd_pkg::*;

  // ***************************************************
  // pin history and internal state
  // ***************************************************
  logic              rst_pin_d_reg;   // last reset pin level
  logic              sclk_d_reg;      // last serial clock
  logic              cs_d_reg;        // last select
  logic [15:0]       shift_reg;       // serial input shift
  logic [15:0]       so_shift_reg;    // serial output shift
  logic [4:0]        bit_cnt_reg;     // bits received
  logic [3:0]        out_reg;         // software output state
  logic [3:0]        fault_reg;       // latched faults
  logic [31:0]       wdog_cnt_reg;    // watchdog counter
  logic              wdog_to_reg;     // watchdog expired

  // edge helper, used for every pin edge below
  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  wire cs_rise   = rise(spi.cs_n, cs_d_reg);
  wire cs_fall   = rise(cs_d_reg, spi.cs_n);
  wire sclk_fall = rise(sclk_d_reg, spi.sclk) & ~spi.cs_n;
  wire sclk_rise = rise(spi.sclk, sclk_d_reg) & ~spi.cs_n;
  // reset pin low clears serial, config, fault and watchdog state
  wire pin_clear = ~rst_n | ~reset_pin;
  wire [3:0] addr = shift_reg[ADDR_MSB:ADDR_LSB];
  // only a complete frame is accepted; short or long ones are dropped
  wire frame_ok  = cs_rise & (bit_cnt_reg == 5'(FRAME_BITS));

  // ***************************************************
  // pin history registers
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_pin_d_reg <= 1'b0;
      sclk_d_reg    <= 1'b0;
      cs_d_reg      <= 1'b1;
    end else begin
      rst_pin_d_reg <= reset_pin;
      sclk_d_reg    <= spi.sclk;
      cs_d_reg      <= spi.cs_n;
    end
  end

  // ***************************************************
  // serial receive and transmit
  // ***************************************************
  always_ff @(posedge clk) begin
    if (pin_clear) begin
      shift_reg    <= 16'h0000;
      so_shift_reg <= 16'h0000;
      bit_cnt_reg  <= 5'h00;
      so           <= 1'b0;
      so_oe        <= 1'b0;
    end else begin
      so_oe <= ~spi.cs_n;
      if (cs_fall) begin
        so_shift_reg <= {4'h0, fault_reg, out_reg, 4'h0};
        bit_cnt_reg  <= 5'h00;
      end else if (sclk_fall) begin
        shift_reg <= {shift_reg[14:0], spi.si};
        if (bit_cnt_reg != 5'h1f) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
      if (cs_fall) begin
        so <= 1'b0;
      end else if (sclk_rise) begin
        so           <= so_shift_reg[15];
        so_shift_reg <= {so_shift_reg[14:0], 1'b0};
      end
    end
  end

  // ***************************************************
  // configuration registers
  // ***************************************************
  always_ff @(posedge clk) begin
    if (pin_clear) begin
      current_sense_out <= '{hiz: 1'b1, sel: wrd_sel_t'(SENSE_RST)};
      out_reg           <= OUT_RST;
    end else if (frame_ok) begin
      case (addr)
        ADDR_SENSE: begin
          current_sense_out.sel <= (shift_reg[2:0] > 3'h4) ?
            WRD_SEL_TEMP : wrd_sel_t'(shift_reg[2:0]);
          current_sense_out.hiz <= shift_reg[3];
        end
        ADDR_OUT: begin
          out_reg <= shift_reg[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ***************************************************
  // fault latch and flag
  // ***************************************************
  always_ff @(posedge clk) begin
    if (pin_clear) begin
      fault_reg        <= 4'h0;
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe  <= 1'b0;
    end else begin
      // new faults win over a software clear in the same cycle
      if (frame_ok && addr == ADDR_FAULT) begin
        fault_reg <= (fault_reg & ~shift_reg[3:0]) | fault_in;
      end else begin
        fault_reg <= fault_reg | fault_in;
      end
      fault_flag_n_oe <= (|fault_reg) | (|fault_in);
    end
  end

  // ***************************************************
  // wake, watchdog and mode
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awake <= 1'b0;
    end else begin
      // reset low sleeps if nothing else wakes
      // wake pin and direct inputs still wake a held reset,
      // but config stays cleared while reset is low
      // direct inputs wake
      awake <= reset_pin | wake_pin | (|direct_in);
    end
  end

  always_ff @(posedge clk) begin
    if (pin_clear) begin
      wdog_cnt_reg <= 32'h0;
      wdog_running <= 1'b0;
      wdog_to_reg  <= 1'b0;
    end else if (rise(reset_pin, rst_pin_d_reg)) begin
      wdog_cnt_reg <= 32'h0;
      wdog_running <= 1'b1;
    end else if (frame_ok) begin
      // any good frame services the watchdog
      wdog_cnt_reg <= 32'h0;
    end else if (wdog_running && !wdog_to_reg) begin
      if (wdog_cnt_reg == 32'(WDOG_CYCLES - 1)) begin
        wdog_to_reg <= 1'b1;
      end else begin
        wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
      end
    end
  end

  // ***************************************************
  // output drive
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failsafe          <= 1'b0;
      high_side_outputs <= 4'h0;
      pwm_clk           <= 1'b0;
    end else begin
      failsafe <= vdd_fail |
                  (wdog_to_reg & failsafe_select_in);
      pwm_clk <= direct_in[0];
      if (!awake) begin
        high_side_outputs <= 4'h0;
      end else if (failsafe) begin
        high_side_outputs <= direct_in;
      end else begin
        high_side_outputs <= out_reg | direct_in;
      end
    end
  end
endmodule

// file: verilog/wrd_pkg.sv
// package of constants and carrier types for the wake/reset/direct-input block
package wrd_pkg;
  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_MHZ         = 50;   // system clock rate
  localparam int RST_LOW_MIN_US  = 10;   // least reset low time
  localparam int RST_LOW_CYC     = RST_LOW_MIN_US * CLK_MHZ;
  localparam int WDOG_TIMEOUT_MS = 250;  // watchdog period, plain default
  localparam int WDOG_CYC        = WDOG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int FRAME_BITS      = 16;   // serial frame length
  // ***************************************************
  // frame fields and reset values
  // ***************************************************
  localparam int ADDR_MSB        = 15;   // 4-bit register address
  localparam int ADDR_LSB        = 12;
  localparam logic [3:0] ADDR_SENSE = 4'h1;  // sense config register
  localparam logic [3:0] ADDR_OUT   = 4'h2;  // output control register
  localparam logic [3:0] ADDR_FAULT = 4'h3;  // fault clear register
  localparam logic [2:0] SENSE_RST  = 3'h0;  // sense off reset value
  localparam logic [3:0] OUT_RST    = 4'h0;  // outputs off reset value
  // ***************************************************
  // carrier types
  // ***************************************************
  typedef enum logic [2:0] {
    WRD_SEL_HS0, WRD_SEL_HS1, WRD_SEL_HS2, WRD_SEL_HS3, WRD_SEL_TEMP
  } wrd_sel_t;
  typedef struct packed {
    logic       hiz;   // sense output tri-stated
    wrd_sel_t   sel;   // reported quantity
  } wrd_sense_t;
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       si;
  } wrd_spi_t;
endpackage
